// ---- hdl/jcra_consts.svh ----
// constants for the boundary-scan configuration access block
// assumes: included by the package and the top module only
`ifndef JCRA_CONSTS_SVH
`define JCRA_CONSTS_SVH

// ----------------------------------------
// instruction register
// ----------------------------------------
`define JCRA_IR_LEN 10
`define JCRA_IR_CFG_IN 10'h3C5
`define JCRA_IR_CFG_OUT 10'h3C4
`define JCRA_IR_BYPASS 10'h3FF
`define JCRA_IR_CAPTURE 10'h001

// ----------------------------------------
// packet words
// ----------------------------------------
`define JCRA_WORD_W 32
`define JCRA_BCNT_W 5
`define JCRA_WORD_LAST 5'h1F
`define JCRA_FIFO_DEPTH 8
`define JCRA_SYNC_WORD 32'hAA995566
`define JCRA_NO_OPERATION_PACKET_WORD 32'h20000000
`define JCRA_STAT_READ_HDR 32'h2800E001

`endif

// ---- hdl/jcra_pkg.sv ----
// types shared by the configuration access block
// assumes: jcra_consts.svh is on the include path
`default_nettype none

package jcra_pkg;
    `include "jcra_consts.svh"

    // ----------------------------------------
    // tap controller states
    // ----------------------------------------
    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
        TAP_EX1_IR = 4'hC, TAP_PAU_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
    } jcra_tap_t;

    // ----------------------------------------
    // state of the link-clock side
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] rs;
        jcra_tap_t st;
        logic [`JCRA_IR_LEN-1:0] ir;
        logic [`JCRA_IR_LEN-1:0] irsh;
        logic [`JCRA_WORD_W-1:0] dsh;
        logic [`JCRA_BCNT_W-1:0] bcnt;
        logic byp;
        logic tdo;
        logic oe_n;
        logic wval;
        logic [`JCRA_WORD_W-1:0] wdata;
        logic ovf;
    } jcra_tck_t;

    // ----------------------------------------
    // state of the system-clock side
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ovf;
    } jcra_clk_t;
endpackage : jcra_pkg

`default_nettype wire

// ---- hdl/jcra_fifo.sv ----
// word fifo between the link crossing and the packet processor
// assumes: one clock, synchronous active-low reset, depth a power of two
`timescale 1ns/1ps
`default_nettype none

module jcra_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } jcra_fifo_st_t;

    jcra_fifo_st_t q_q, q_d;
    logic push;
    logic pop;

    // full and empty flags from the fill count
    assign in_ready = q_q.cnt != (AW+1)'(D);
    assign out_valid = q_q.cnt != '0;
    assign out_data = q_q.mem[q_q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointer and count update
    always_comb begin
        q_d = q_q;
        if (push) begin
            q_d.mem[q_q.wp] = in_data;
            q_d.wp = q_q.wp + 1'b1;
        end
        if (pop) begin
            q_d.rp = q_q.rp + 1'b1;
        end
        if (push && !pop) begin
            q_d.cnt = q_q.cnt + 1'b1;
        end else if (pop && !push) begin
            q_d.cnt = q_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end
endmodule : jcra_fifo

`default_nettype wire

// ---- hdl/jcra_xfer.sv ----
// toggle handshake that carries one held word between two clocks
// assumes: each side has its own synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module jcra_xfer #(
    parameter int W = 32
) (
    input wire logic src_clk,
    input wire logic src_resetn,
    input wire logic s_valid,
    input wire logic [W-1:0] s_data,
    output logic s_ready,
    input wire logic dst_clk,
    input wire logic dst_resetn,
    output logic d_valid,
    output logic [W-1:0] d_data,
    input wire logic d_ready
);
    typedef struct packed {
        logic req;
        logic [1:0] ack;
        logic busy;
        logic [W-1:0] data;
    } jcra_xsrc_t;

    typedef struct packed {
        logic ack;
        logic [1:0] req;
        logic valid;
        logic [W-1:0] data;
    } jcra_xdst_t;

    jcra_xsrc_t s_q, s_d;
    jcra_xdst_t d_q, d_d;

    assign s_ready = !s_q.busy;
    assign d_valid = d_q.valid;
    assign d_data = d_q.data;

    // source: hold word and toggle request until ack returns
    always_comb begin
        s_d = s_q;
        s_d.ack = {s_q.ack[0], d_q.ack};
        if (!s_q.busy && s_valid) begin
            s_d.data = s_data;
            s_d.req = !s_q.req;
            s_d.busy = 1'b1;
        end else if (s_q.busy && s_q.ack[1] == s_q.req) begin
            s_d.busy = 1'b0;
        end
    end

    always_ff @(posedge src_clk) begin
        if (!src_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // destination: take the held word once the request is seen
    always_comb begin
        d_d = d_q;
        d_d.req = {d_q.req[0], s_q.req};
        if (d_q.valid && d_ready) begin
            d_d.valid = 1'b0;
        end
        if (!d_q.valid && d_q.req[1] != d_q.ack) begin
            d_d.data = s_q.data;
            d_d.valid = 1'b1;
            d_d.ack = d_q.req[1];
        end
    end

    always_ff @(posedge dst_clk) begin
        if (!dst_resetn) begin
            d_q <= '0;
        end else begin
            d_q <= d_d;
        end
    end
endmodule : jcra_xfer

`default_nettype wire

// ---- hdl/jcra_top.sv ----
// boundary-scan access to the configuration packet processor
// assumes: tck comes from the external scan controller and may stop;
// the packet processor and readback source run on clk
`timescale 1ns/1ps
`default_nettype none
`include "jcra_consts.svh"

// What this block does
// - packet input words go to packet processor; a word finished while the previous one still waits is dropped
// - commands in via input, results via readback
// - ten-bit instruction, LSB first, selects register
// - packet words move MSB first both ways
// - readable registers readable through scan path
// - status read uses the fixed five words
// - readback instruction delivers 32-bit word
// - scan packets identical to parallel port packets
module jcra_top
    import jcra_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    output logic pkt_valid,
    output logic [`JCRA_WORD_W-1:0] pkt_data,
    input wire logic pkt_ready,
    input wire logic rb_valid,
    input wire logic [`JCRA_WORD_W-1:0] rb_data,
    output logic rb_ready,
    output logic pkt_overrun
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    jcra_tck_t s_q, s_d;
    jcra_clk_t c_q, c_d;
    logic rst_tck_n;
    logic sel_in;
    logic sel_out;
    logic last_bit;
    logic [`JCRA_WORD_W-1:0] shin;
    logic xs_ready;
    logic rbv;
    logic [`JCRA_WORD_W-1:0] rbd;
    logic rb_take;
    logic xp_valid;
    logic [`JCRA_WORD_W-1:0] xp_data;
    logic xp_ready;

    // ----------------------------------------
    // tap next-state function
    // ----------------------------------------
    function automatic jcra_tap_t tap_next(input jcra_tap_t s, input logic m);
        unique case (s)
            TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
        endcase
    endfunction : tap_next

    // ----------------------------------------
    // link-clock side decode
    // ----------------------------------------
    assign rst_tck_n = s_q.rs[1];
    assign sel_in = s_q.ir == `JCRA_IR_CFG_IN;
    assign sel_out = s_q.ir == `JCRA_IR_CFG_OUT;
    assign last_bit = s_q.bcnt == `JCRA_WORD_LAST;
    // word as it stands after this shift, MSB first
    assign shin = {s_q.dsh[`JCRA_WORD_W-2:0], tdi};
    // readback word taken at capture and at each word edge
    assign rb_take = sel_out & ((s_q.st == TAP_CAP_DR) | ((s_q.st == TAP_SH_DR) & last_bit));
    assign tdo = s_q.tdo;
    assign tdo_oe_n = s_q.oe_n;

    // link-clock side next state
    always_comb begin
        s_d = s_q;
        s_d.rs = {s_q.rs[0], resetn};
        s_d.st = tap_next(s_q.st, tms);
        if (s_q.wval && xs_ready) begin
            s_d.wval = 1'b0;
        end
        unique case (s_q.st)
            TAP_TLR: begin
                s_d.ir = `JCRA_IR_BYPASS;
                s_d.ovf = 1'b0;
            end
            TAP_CAP_IR: begin
                s_d.irsh = `JCRA_IR_CAPTURE;
            end
            TAP_SH_IR: begin
                s_d.irsh = {tdi, s_q.irsh[`JCRA_IR_LEN-1:1]};
            end
            TAP_UPD_IR: begin
                s_d.ir = s_q.irsh;
            end
            TAP_CAP_DR: begin
                s_d.bcnt = '0;
                s_d.byp = 1'b0;
                s_d.dsh = (sel_out && rbv) ? rbd : '0;
            end
            TAP_SH_DR: begin
                s_d.bcnt = s_q.bcnt + 1'b1;
                if (sel_in || sel_out) begin
                    s_d.dsh = shin;
                end else begin
                    s_d.byp = tdi;
                end
                // whole input word goes to processor, or is dropped with ovf set if the previous one still waits
                if (sel_in && last_bit) begin
                    if (s_q.wval && !xs_ready) begin
                        s_d.ovf = 1'b1;
                    end else begin
                        s_d.wval = 1'b1;
                        s_d.wdata = shin;
                    end
                end
                if (sel_out && last_bit) begin
                    s_d.dsh = rbv ? rbd : '0;
                end
            end
            default: begin
            end
        endcase
        // only shift states drive the output pin
        s_d.oe_n = !(s_d.st == TAP_SH_DR || s_d.st == TAP_SH_IR);
        if (s_d.st == TAP_SH_IR) begin
            s_d.tdo = s_d.irsh[0];
        end else if (s_d.st == TAP_SH_DR) begin
            s_d.tdo = (sel_in || sel_out) ? s_d.dsh[`JCRA_WORD_W-1] : s_d.byp;
        end else begin
            s_d.tdo = 1'b0;
        end
    end

    // link-clock side registers; reset sync flops always run
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            s_q <= '{rs: s_d.rs, st: TAP_TLR, ir: `JCRA_IR_BYPASS, oe_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // clock crossings
    // ----------------------------------------
    // input words cross unchanged to the processor
    jcra_xfer #(.W(`JCRA_WORD_W)) u_pkt_xfer (
        .src_clk(tck),
        .src_resetn(rst_tck_n),
        .s_valid(s_q.wval),
        .s_data(s_q.wdata),
        .s_ready(xs_ready),
        .dst_clk(clk),
        .dst_resetn(resetn),
        .d_valid(xp_valid),
        .d_data(xp_data),
        .d_ready(xp_ready)
    );

    // results return only through the readback path
    jcra_xfer #(.W(`JCRA_WORD_W)) u_rb_xfer (
        .src_clk(clk),
        .src_resetn(resetn),
        .s_valid(rb_valid),
        .s_data(rb_data),
        .s_ready(rb_ready),
        .dst_clk(tck),
        .dst_resetn(rst_tck_n),
        .d_valid(rbv),
        .d_data(rbd),
        .d_ready(rb_take)
    );

    // ----------------------------------------
    // system-clock side
    // ----------------------------------------
    jcra_fifo #(.W(`JCRA_WORD_W), .D(`JCRA_FIFO_DEPTH)) u_pkt_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(xp_valid),
        .in_data(xp_data),
        .in_ready(xp_ready),
        .out_valid(pkt_valid),
        .out_data(pkt_data),
        .out_ready(pkt_ready)
    );

    // overrun level brought over by two flops
    always_comb begin
        c_d = c_q;
        c_d.ovf = {c_q.ovf[0], s_q.ovf};
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign pkt_overrun = c_q.ovf[1];

    // ----------------------------------------
    // assertions, link-clock side
    // ----------------------------------------
    property p_word_forward;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_SH_DR && sel_in && last_bit && !s_q.wval)
            |=> (s_q.wval && s_q.wdata == $past(shin));
    endproperty
    a_word_forward: assert property (p_word_forward)
        else $error("input word not forwarded");

    property p_no_out_words;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_SH_DR && !sel_in && !s_q.wval) |=> !s_q.wval;
    endproperty
    a_no_out_words: assert property (p_no_out_words)
        else $error("packet word raised outside input instruction");

    property p_ir_load;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_SH_IR && !tms) ##1 (s_q.st == TAP_SH_IR && tms) ##1 tms
            |=> ##1 (s_q.ir == $past(s_q.irsh, 2));
    endproperty
    a_ir_load: assert property (p_ir_load)
        else $error("instruction not loaded from shift stage");

    property p_msb_first;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_SH_DR && sel_out && !last_bit && !tms)
            |=> (!tdo_oe_n && tdo == $past(s_q.dsh[30]));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("readback bit order wrong");

    property p_capture_word;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_CAP_DR && sel_out && rbv && !tms)
            |=> (s_q.dsh == $past(rbd) && tdo == $past(rbd[31]));
    endproperty
    a_capture_word: assert property (p_capture_word)
        else $error("readback word not captured");

    property p_reload_word;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_SH_DR && sel_out && last_bit && rbv)
            |=> (s_q.dsh == $past(rbd) && !rbv ##1 1'b1);
    endproperty
    a_reload_word: assert property (p_reload_word)
        else $error("readback word not reloaded at word edge");

    property p_tap_reset;
        @(posedge tck) disable iff (!rst_tck_n)
        tms [*5] |=> (s_q.st == TAP_TLR) ##1 (s_q.ir == `JCRA_IR_BYPASS);
    endproperty
    a_tap_reset: assert property (p_tap_reset)
        else $error("five TMS highs did not reach reset");

    property p_tap_idle;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_TLR && !tms) |=> (s_q.st == TAP_RTI)
            ##1 (s_q.st == ($past(tms) ? TAP_SEL_DR : TAP_RTI));
    endproperty
    a_tap_idle: assert property (p_tap_idle)
        else $error("tap did not enter idle");

    property p_ovf_clear;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_TLR) |=> !s_q.ovf;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overrun flag not cleared in tap reset");

    property p_bypass_bit;
        @(posedge tck) disable iff (!rst_tck_n)
        (s_q.st == TAP_SH_DR && !sel_in && !sel_out && !tms)
            |=> (!tdo_oe_n && tdo == $past(tdi));
    endproperty
    a_bypass_bit: assert property (p_bypass_bit)
        else $error("bypass bit not passed through");

    // ----------------------------------------
    // assertions, system-clock side
    // ----------------------------------------
    property p_stream_hold;
        @(posedge clk) disable iff (!resetn)
        (pkt_valid && !pkt_ready) |=> (pkt_valid && $stable(pkt_data));
    endproperty
    a_stream_hold: assert property (p_stream_hold)
        else $error("packet word changed while stalled");

    property p_sync_seen;
        @(posedge clk) disable iff (!resetn)
        (xp_valid && xp_ready && xp_data == `JCRA_SYNC_WORD && u_pkt_fifo.q_q.cnt == '0)
            |=> (pkt_valid && pkt_data == `JCRA_SYNC_WORD);
    endproperty
    a_sync_seen: assert property (p_sync_seen)
        else $error("sync word not presented in order");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_sync_word: cover property (@(posedge clk) disable iff (!resetn)
        pkt_valid && pkt_ready && pkt_data == `JCRA_SYNC_WORD);
    c_stat_hdr: cover property (@(posedge clk) disable iff (!resetn)
        pkt_valid && pkt_ready && pkt_data == `JCRA_STAT_READ_HDR);
    c_rb_capture: cover property (@(posedge tck) disable iff (!rst_tck_n)
        s_q.st == TAP_CAP_DR && sel_out && rbv);
    c_overrun: cover property (@(posedge clk) disable iff (!resetn)
        $rose(pkt_overrun));
    c_rb_reload: cover property (@(posedge tck) disable iff (!rst_tck_n)
        s_q.st == TAP_SH_DR && sel_out && last_bit && rbv);

endmodule : jcra_top

`default_nettype wire

// ---- dv/jcra_scan_ctrl.sv ----
// model of the external scan controller that drives the link
// assumes: tck stands low between frames; tdo is sampled just before each rising tck
`timescale 1ns/1ps
`default_nettype none

module jcra_scan_ctrl #(
    parameter int HALF = 32
) (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic [31:0] tx_q[$];
    logic [31:0] rx_q[$];
    logic oe_bad;

    // idle levels at time zero
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        oe_bad = 1'b0;
    end

    // ----------------------------------------
    // one link clock period
    // ----------------------------------------
    // outside a shift tdi shows the inverse of its last value
    task automatic step(input logic m, input logic d, input logic use_d, output logic o);
        tms = m;
        tdi = use_d ? d : ~tdi;
        #(HALF);
        o = tdo;
        tck = 1'b1;
        #(HALF);
        tck = 1'b0;
    endtask : step

    task automatic idle(input logic m, input int n);
        logic o;
        repeat (n) step(m, 1'b0, 1'b0, o);
    endtask : idle

    task automatic tap_reset();
        idle(1'b1, 5);
    endtask : tap_reset

    task automatic to_shift_ir(input int n);
        idle(1'b1, n);
        idle(1'b0, 2);
    endtask : to_shift_ir

    task automatic load_ir(input logic [9:0] ir, output logic [9:0] cap);
        for (int i = 0; i < 10; i++) begin
            step(i == 9, ir[i], 1'b1, cap[i]);
        end
        idle(1'b1, 2);
        idle(1'b0, 2);
    endtask : load_ir

    task automatic shift_dr(input int nbits);
        logic o;
        logic [31:0] w;
        w = '0;
        rx_q.delete();
        for (int k = 0; k < nbits; k++) begin
            if (tdo_oe_n !== 1'b0) oe_bad = 1'b1;
            step(k == nbits - 1, tx_q[k / 32][31 - k % 32], 1'b1, o);
            w = {w[30:0], o};
            if (k % 32 == 31 || k == nbits - 1) begin
                rx_q.push_back(w);
                w = '0;
            end
        end
    endtask : shift_dr
endmodule : jcra_scan_ctrl

`default_nettype wire

// ---- dv/test_jtag_config_register_access.sv ----
// self-checking bench for the boundary-scan configuration access block
// assumes: scan controller model in jcra_scan_ctrl.sv, headers on the include path
`timescale 1ns/1ps
`default_nettype none

module test_jtag_config_register_access;
    logic clk;
    logic resetn;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic pkt_valid;
    logic [31:0] pkt_data;
    logic pkt_ready;
    logic rb_valid;
    logic [31:0] rb_data;
    logic rb_ready;
    logic pkt_overrun;
    logic sink_hold;
    logic [31:0] got_q[$];
    int err_total = 0;
    int comparisons = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    jcra_top jcra_top_i (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_ready(pkt_ready), .rb_valid(rb_valid), .rb_data(rb_data), .rb_ready(rb_ready),
        .pkt_overrun(pkt_overrun));

    jcra_scan_ctrl jcra_scan_ctrl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));

    // ----------------------------------------
    // checks, verdict and expectations
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("%0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [31:0] stat_word(input int i);
        return (i == 0) ? 32'hAA995566 : (i == 2) ? 32'h2800E001 : 32'h20000000;
    endfunction : stat_word

    // bypass returns a captured zero, then tdi one bit late
    function automatic logic [31:0] bypass_exp(input logic [31:0] w);
        return w >> 13;
    endfunction : bypass_exp

    // ----------------------------------------
    // packet sink and readback source
    // ----------------------------------------
    // sink takes words at random, or stalls on request
    always @(posedge clk) begin
        if (pkt_valid === 1'b1 && pkt_ready === 1'b1) got_q.push_back(pkt_data);
        pkt_ready <= sink_hold ? 1'b0 : 1'($urandom % 2);
    end

    task automatic offer_rb(input logic [31:0] w);
        int n;
        n = 0;
        @(posedge clk);
        rb_valid <= 1'b1;
        rb_data <= w;
        do begin
            @(posedge clk);
            n++;
        end while (rb_ready !== 1'b1 && n < 1000);
        rb_valid <= 1'b0;
        rb_data <= ~w;
    endtask : offer_rb

    // waits until the packet stream has been quiet for 20 cycles
    task automatic drain();
        int idle_n;
        idle_n = 0;
        for (int n = 0; n < 2000 && idle_n < 20; n++) begin
            @(posedge clk);
            idle_n = (pkt_valid === 1'b0) ? idle_n + 1 : 0;
        end
    endtask : drain

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [9:0] cap;
        logic [31:0] rb_w;
        logic [31:0] sent[$];
        logic [31:0] rb_w2;
        resetn = 1'b0;
        rb_valid = 1'b0;
        rb_data = 32'h0;
        sink_hold = 1'b0;
        void'($urandom(32'h448AC3D6));
        fork
            repeat (10) @(posedge clk);
            begin
                #1;
                jcra_scan_ctrl_i.tap_reset();
            end
        join
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check({30'h0, tdo, tdo_oe_n}, 32'h1);
        rb_w = $urandom;
        offer_rb(rb_w);
        jcra_scan_ctrl_i.tap_reset();
        // second word waits behind the first, reloads at the word edge
        rb_w2 = $urandom;
        offer_rb(rb_w2);
        jcra_scan_ctrl_i.idle(1'b0, 1);
        jcra_scan_ctrl_i.to_shift_ir(2);
        jcra_scan_ctrl_i.load_ir(10'h3C5, cap);
        check({22'h0, cap}, 32'h1);
        jcra_scan_ctrl_i.tx_q = {stat_word(0), stat_word(1), stat_word(2), stat_word(3),
            stat_word(4)};
        jcra_scan_ctrl_i.shift_dr(160);
        jcra_scan_ctrl_i.to_shift_ir(3);
        jcra_scan_ctrl_i.load_ir(10'h3C4, cap);
        jcra_scan_ctrl_i.tx_q = {32'h0, 32'h0};
        jcra_scan_ctrl_i.shift_dr(64);
        check(jcra_scan_ctrl_i.rx_q[0], rb_w);
        check(jcra_scan_ctrl_i.rx_q[1], rb_w2);
        check({31'h0, jcra_scan_ctrl_i.oe_bad}, 32'h0);
        jcra_scan_ctrl_i.tap_reset();
        drain();
        check(32'(got_q.size()), 32'h5);
        for (int i = 0; i < 5; i++) check(got_q[i], stat_word(i));
        $display("test status_read done");
        got_q.delete();
        sink_hold <= 1'b1;
        for (int i = 0; i < 12; i++) sent.push_back($urandom);
        jcra_scan_ctrl_i.idle(1'b0, 1);
        jcra_scan_ctrl_i.to_shift_ir(2);
        jcra_scan_ctrl_i.load_ir(10'h3C5, cap);
        jcra_scan_ctrl_i.tx_q = sent;
        jcra_scan_ctrl_i.shift_dr(384);
        jcra_scan_ctrl_i.idle(1'b1, 1);
        jcra_scan_ctrl_i.idle(1'b0, 1);
        @(posedge clk);
        check({31'h0, pkt_valid}, 32'h1);
        check(pkt_data, sent[0]);
        check({31'h0, pkt_overrun}, 32'h1);
        sink_hold <= 1'b0;
        drain();
        check(32'(got_q.size() >= 8), 32'h1);
        for (int i = 0; i < got_q.size(); i++) check(got_q[i], sent[i]);
        jcra_scan_ctrl_i.tap_reset();
        drain();
        check({31'h0, pkt_overrun}, 32'h0);
        $display("test fifo_overrun done");
        got_q.delete();
        jcra_scan_ctrl_i.idle(1'b0, 1);
        jcra_scan_ctrl_i.to_shift_ir(2);
        jcra_scan_ctrl_i.load_ir(10'h3FF, cap);
        jcra_scan_ctrl_i.tx_q = {sent[1]};
        jcra_scan_ctrl_i.shift_dr(20);
        check(jcra_scan_ctrl_i.rx_q[0], bypass_exp(sent[1]));
        jcra_scan_ctrl_i.to_shift_ir(3);
        jcra_scan_ctrl_i.load_ir(10'h3C5, cap);
        jcra_scan_ctrl_i.shift_dr(20);
        jcra_scan_ctrl_i.tap_reset();
        drain();
        check(32'(got_q.size()), 32'h0);
        $display("test bypass_partial done");
        end_of_test();
    end

    // watchdog well beyond the expected run of about 50 us
    initial begin
        #200000;
        err_total++;
        $display("wrong value at %0t: run did not finish", $time);
        end_of_test();
    end
endmodule : test_jtag_config_register_access

`default_nettype wire
